// File: design/dsos_pkg.sv
// package: constants for the drive status output selector
package dsos_pkg;
  // function codes
  localparam logic [5:0] FN_STOP = 6'h0F;
  localparam logic [5:0] FN_STEADY = 6'h10;
  localparam logic [5:0] FN_INV_LINE = 6'h11;
  localparam logic [5:0] FN_COMM_LINE = 6'h12;
  localparam logic [5:0] FN_SPEED_SEARCH = 6'h13;
  localparam logic [5:0] FN_READY = 6'h16;
  localparam logic [5:0] FN_TIMER = 6'h1C;
  localparam logic [5:0] FN_TRIP = 6'h1D;
  localparam logic [5:0] FN_ONOFF = 6'h22;
  localparam logic [5:0] FN_BRAKE = 6'h23;
  localparam logic [5:0] FN_KEB = 6'h28;
  // register byte offsets
  localparam logic [7:0] OFS_TERM_SEL = 8'h00;
  localparam logic [7:0] OFS_RELAY_SEL = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_ON_DLY = 8'h0C;
  localparam logic [7:0] OFS_OFF_DLY = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // reset values and delay limit
  localparam logic [5:0] RST_TERM_SEL = 6'h0E;
  localparam logic [5:0] RST_RELAY_SEL = 6'h1D;
  localparam logic [2:0] RST_MASK = 3'h2;
  localparam logic [13:0] RST_DLY = 14'h0000;
  localparam logic [13:0] DLY_MAX = 14'h2710;
  // delay tick: 10 ms at 100 MHz
  localparam int CLK_HZ = 100000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYC - 1);
  // trip output states
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_ASSERT_WAIT = 2'b01,
    TS_ACTIVE = 2'b10,
    TS_RELEASE_WAIT = 2'b11
  } dsos_trip_state_t;
endpackage : dsos_pkg

// File: design/dsos_top.sv
// module: status source selector with fault trip output timing
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// R01: code 15: stopped, no output voltage
// R02: code 16: steady speed operation
// R03: code 17: motor on inverter line
// R04: code 18: motor on commercial mains
// R05: code 19: speed search in progress
// R06: code 22: ready for external run
// R07: code 28: timer function output
// R08: code 29: masked, delayed fault trip
// R09: code 34: analog on/off comparison output
// R10: code 35: mechanical brake release
// R11: code 40: energy buffering until power returns
// R12: operator programs code 29 for trip
// R13: mask bit1: low-voltage trips
// R14: mask bit2: other fault trips
// R15: mask bit3: auto restart failure
// R16: mask resets to 010
// R17: assert delay 0.00-100.00 s, default 0
// R18: release delay after trip clears
// R19: mask bits independent, any match
// R20: delays in 10 ms steps, zero immediate
module dsos_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // status sources, same clock domain
  input wire logic run_cmd_i,
  input wire logic out_voltage_i,
  input wire logic steady_i,
  input wire logic inv_line_i,
  input wire logic comm_line_i,
  input wire logic speed_search_i,
  input wire logic ready_i,
  input wire logic timer_out_i,
  input wire logic onoff_ctrl_i,
  input wire logic brake_release_i,
  input wire logic energy_buffering_i,
  // trip causes, levels held until initialization
  input wire logic trip_low_voltage_i,
  input wire logic trip_other_i,
  input wire logic restart_fail_i,
  // field outputs
  output logic open_collector_output_o,
  output logic relay_output_o
);
  ////////////////////////////////////////////////////////////////////
  // registers
  logic [5:0] term_sel, next_term_sel;
  logic [5:0] relay_sel, next_relay_sel;
  logic [2:0] mask, next_mask;
  logic [13:0] on_dly, next_on_dly;
  logic [13:0] off_dly, next_off_dly;
  logic [31:0] rd_data, next_rd_data;
  logic ack, next_ack;
  logic wr_en;
  logic [13:0] wr_dly;
  logic trip_qual;
  logic trip_out, next_trip_out;

  always_comb begin
    wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack;
    wr_dly = (wb_dat_i[13:0] > dsos_pkg::DLY_MAX) ? dsos_pkg::DLY_MAX : wb_dat_i[13:0];
    next_term_sel = term_sel;
    next_relay_sel = relay_sel;
    next_mask = mask;
    next_on_dly = on_dly;
    next_off_dly = off_dly;
    next_ack = wb_cyc_i && wb_stb_i && !ack;
    next_rd_data = 32'h0000_0000;
    if (wr_en && wb_sel_i[0]) begin
      case (wb_adr_i)
        dsos_pkg::OFS_TERM_SEL: next_term_sel = wb_dat_i[5:0];
        dsos_pkg::OFS_RELAY_SEL: next_relay_sel = wb_dat_i[5:0];
        dsos_pkg::OFS_MASK: next_mask = wb_dat_i[3:1];
        dsos_pkg::OFS_ON_DLY: next_on_dly = wr_dly; // R17
        dsos_pkg::OFS_OFF_DLY: next_off_dly = wr_dly; // R18
        default: ;
      endcase
    end
    case (wb_adr_i)
      dsos_pkg::OFS_TERM_SEL: next_rd_data = {26'h0, term_sel};
      dsos_pkg::OFS_RELAY_SEL: next_rd_data = {26'h0, relay_sel};
      dsos_pkg::OFS_MASK: next_rd_data = {28'h0, mask, 1'b0};
      dsos_pkg::OFS_ON_DLY: next_rd_data = {18'h0, on_dly};
      dsos_pkg::OFS_OFF_DLY: next_rd_data = {18'h0, off_dly};
      dsos_pkg::OFS_STATUS: next_rd_data = {28'h0, trip_qual, trip_out,
                                            relay_output_o, open_collector_output_o};
      default: next_rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_sel <= dsos_pkg::RST_TERM_SEL;
      relay_sel <= dsos_pkg::RST_RELAY_SEL;
      mask <= dsos_pkg::RST_MASK; // R16
      on_dly <= dsos_pkg::RST_DLY;
      off_dly <= dsos_pkg::RST_DLY;
      rd_data <= 32'h0000_0000;
      ack <= 1'b0;
    end else begin
      term_sel <= next_term_sel;
      relay_sel <= next_relay_sel;
      mask <= next_mask;
      on_dly <= next_on_dly;
      off_dly <= next_off_dly;
      rd_data <= next_rd_data;
      ack <= next_ack;
    end
  end
  assign wb_dat_o = rd_data;
  assign wb_ack_o = ack;

  ////////////////////////////////////////////////////////////////////
  // fault trip qualification and delays
  dsos_pkg::dsos_trip_state_t tstate, next_tstate;
  logic [13:0] dcnt, next_dcnt;
  logic [19:0] tick_cnt, next_tick_cnt;
  logic tick;

  always_comb begin
    trip_qual = (mask[0] && trip_low_voltage_i) || (mask[1] && trip_other_i) // R13 R14 R19
             || (mask[2] && restart_fail_i); // R15
    tick = (tick_cnt == dsos_pkg::TICK_LAST);
    next_tick_cnt = (tick || tstate == dsos_pkg::TS_IDLE || tstate == dsos_pkg::TS_ACTIVE)
                    ? 20'h00000 : tick_cnt + 20'h00001; // R20
    next_tstate = tstate;
    next_dcnt = dcnt;
    next_trip_out = trip_out;
    case (tstate)
      dsos_pkg::TS_IDLE: begin
        next_dcnt = 14'h0000;
        if (trip_qual) begin
          if (on_dly == 14'h0000) begin
            next_tstate = dsos_pkg::TS_ACTIVE; // R20
            next_trip_out = 1'b1;
          end else begin
            next_tstate = dsos_pkg::TS_ASSERT_WAIT;
          end
        end
      end
      dsos_pkg::TS_ASSERT_WAIT: begin
        if (!trip_qual) begin
          next_tstate = dsos_pkg::TS_IDLE;
        end else if (tick) begin
          next_dcnt = dcnt + 14'h0001;
          if (dcnt + 14'h0001 >= on_dly) begin
            next_tstate = dsos_pkg::TS_ACTIVE; // R17
            next_trip_out = 1'b1;
          end
        end
      end
      dsos_pkg::TS_ACTIVE: begin
        next_dcnt = 14'h0000;
        if (!trip_qual) begin
          if (off_dly == 14'h0000) begin
            next_tstate = dsos_pkg::TS_IDLE;
            next_trip_out = 1'b0;
          end else begin
            next_tstate = dsos_pkg::TS_RELEASE_WAIT;
          end
        end
      end
      dsos_pkg::TS_RELEASE_WAIT: begin
        if (trip_qual) begin
          next_tstate = dsos_pkg::TS_ACTIVE;
        end else if (tick) begin
          next_dcnt = dcnt + 14'h0001;
          if (dcnt + 14'h0001 >= off_dly) begin
            next_tstate = dsos_pkg::TS_IDLE; // R18
            next_trip_out = 1'b0;
          end
        end
      end
      default: begin
        next_tstate = dsos_pkg::TS_IDLE;
        next_trip_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tstate <= dsos_pkg::TS_IDLE;
      dcnt <= 14'h0000;
      tick_cnt <= 20'h00000;
      trip_out <= 1'b0;
    end else begin
      tstate <= next_tstate;
      dcnt <= next_dcnt;
      tick_cnt <= next_tick_cnt;
      trip_out <= next_trip_out;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // source selection
  function automatic logic pick(input logic [5:0] code, input logic trip);
    case (code)
      dsos_pkg::FN_STOP: pick = !run_cmd_i && !out_voltage_i; // R01
      dsos_pkg::FN_STEADY: pick = steady_i; // R02
      dsos_pkg::FN_INV_LINE: pick = inv_line_i; // R03
      dsos_pkg::FN_COMM_LINE: pick = comm_line_i; // R04
      dsos_pkg::FN_SPEED_SEARCH: pick = speed_search_i; // R05
      dsos_pkg::FN_READY: pick = ready_i; // R06
      dsos_pkg::FN_TIMER: pick = timer_out_i; // R07
      dsos_pkg::FN_TRIP: pick = trip; // R08 R12
      dsos_pkg::FN_ONOFF: pick = onoff_ctrl_i; // R09
      dsos_pkg::FN_BRAKE: pick = brake_release_i; // R10
      dsos_pkg::FN_KEB: pick = energy_buffering_i; // R11
      default: pick = 1'b0;
    endcase
  endfunction : pick

  logic next_term_out, next_relay_out;
  always_comb begin
    next_term_out = pick(term_sel, trip_out);
    next_relay_out = pick(relay_sel, trip_out);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_collector_output_o <= 1'b0;
      relay_output_o <= 1'b0;
    end else begin
      open_collector_output_o <= next_term_out;
      relay_output_o <= next_relay_out;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  mask_reset_a: assert property (@(posedge clk_i) // R16
    $fell(rst_i) |-> mask == 3'h2) else $error("mask reset value wrong");
  stop_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    term_sel == dsos_pkg::FN_STOP && $stable(term_sel)
    |=> open_collector_output_o == (!$past(run_cmd_i) && !$past(out_voltage_i)))
    else $error("stop output wrong");
  keb_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    relay_sel == dsos_pkg::FN_KEB && $stable(relay_sel)
    |=> relay_output_o == $past(energy_buffering_i)) else $error("keb output wrong");
  zero_on_a: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    tstate == dsos_pkg::TS_IDLE && trip_qual && on_dly == 14'h0000 |=> trip_out)
    else $error("zero delay not immediate");
  qual_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    tstate == dsos_pkg::TS_IDLE && mask[0] && trip_low_voltage_i && on_dly == 14'h0000
    |=> trip_out) else $error("low voltage not qualified");
  qual_none_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    tstate == dsos_pkg::TS_IDLE && !(mask[0] && trip_low_voltage_i)
    && !(mask[1] && trip_other_i) && !(mask[2] && restart_fail_i)
    |=> !trip_out) else $error("qualification wrong");
  early_on_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    tstate == dsos_pkg::TS_ASSERT_WAIT && dcnt + 14'h0001 < on_dly |=> !trip_out)
    else $error("trip output early");
  early_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    tstate == dsos_pkg::TS_RELEASE_WAIT && dcnt + 14'h0001 < off_dly |=> trip_out)
    else $error("trip release early");
  trip_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // R08
    term_sel == dsos_pkg::FN_TRIP && $stable(term_sel)
    |=> open_collector_output_o == $past(trip_out)) else $error("trip route wrong");
  relay_trip_a: assert property (@(posedge clk_i) disable iff (rst_i) // R08
    relay_sel == dsos_pkg::FN_TRIP && $stable(relay_sel)
    |=> relay_output_o == $past(trip_out)) else $error("relay trip route wrong");
  state_out_a: assert property (@(posedge clk_i) disable iff (rst_i) // R08
    trip_out == (tstate == dsos_pkg::TS_ACTIVE || tstate == dsos_pkg::TS_RELEASE_WAIT))
    else $error("trip output state mismatch");
  restart_qual_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    tstate == dsos_pkg::TS_IDLE && mask[2] && restart_fail_i && on_dly == 14'h0000
    |=> trip_out) else $error("restart failure not qualified");

  // trip timing checks
  dly_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    on_dly <= dsos_pkg::DLY_MAX && off_dly <= dsos_pkg::DLY_MAX)
    else $error("delay above limit");
  cancel_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    tstate == dsos_pkg::TS_ASSERT_WAIT && !trip_qual
    |=> tstate == dsos_pkg::TS_IDLE && !trip_out) else $error("assert wait not cancelled");
  on_late_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    tstate == dsos_pkg::TS_ASSERT_WAIT && trip_qual && tick && dcnt + 14'h0001 >= on_dly
    |=> trip_out) else $error("trip output late");
  rejoin_active_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    tstate == dsos_pkg::TS_RELEASE_WAIT && trip_qual
    |=> tstate == dsos_pkg::TS_ACTIVE && trip_out) else $error("release wait not left");
  off_late_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    tstate == dsos_pkg::TS_RELEASE_WAIT && !trip_qual && tick && dcnt + 14'h0001 >= off_dly
    |=> !trip_out) else $error("trip release late");
  zero_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    tstate == dsos_pkg::TS_ACTIVE && !trip_qual && off_dly == 14'h0000 |=> !trip_out)
    else $error("zero release delay not immediate");

  // register bus checks
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("bus request not acked");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  term_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
    && wb_adr_i == dsos_pkg::OFS_TERM_SEL |=> term_sel == $past(wb_dat_i[5:0]))
    else $error("terminal select not written");
  mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
    && wb_adr_i == dsos_pkg::OFS_MASK |=> mask == $past(wb_dat_i[3:1]))
    else $error("mask not written");
endmodule : dsos_top
`default_nettype wire

// File: testbench/dsos_field_model.sv
// file: field wiring model for terminal and relay
`timescale 1ns/1ns
`default_nettype none
module dsos_field_model (
  // clock
  input wire logic clk_i,
  // block outputs
  input wire logic open_collector_output_i,
  input wire logic relay_output_i,
  // levels seen in the field
  output logic terminal_level_o,
  output logic relay_contact_o
);
  // pull-up on the terminal, the transistor pulls it low while on
  always_ff @(posedge clk_i) begin
    terminal_level_o <= ~open_collector_output_i;
    relay_contact_o <= relay_output_i;
  end
endmodule : dsos_field_model
`default_nettype wire

// File: testbench/dsos_top_test.sv
// file: self-checking bench for the status output selector
`timescale 1ns/1ns
`default_nettype none
module dsos_top_test;
  logic clk_i, rst_i, cyc, stb, we, ack, oc, relay, lvl, contact;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rd, rdat;
  logic [10:0] src;
  logic [2:0] trip;
  int miscompares = 0;
  int n_checks = 0;
  logic [5:0] codes [9] = '{dsos_pkg::FN_STEADY, dsos_pkg::FN_INV_LINE, dsos_pkg::FN_COMM_LINE,
    dsos_pkg::FN_SPEED_SEARCH, dsos_pkg::FN_READY, dsos_pkg::FN_TIMER, dsos_pkg::FN_ONOFF,
    dsos_pkg::FN_BRAKE, dsos_pkg::FN_KEB};
  logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [7:0] rv [5] = '{8'h0E, 8'h1D, 8'h04, 8'h00, 8'h00};
  logic [3:0] mk [6] = '{4'h4, 4'h4, 4'h2, 4'h8, 4'h8, 4'h6};
  logic [2:0] tc [6] = '{3'h1, 3'h2, 3'h1, 3'h4, 3'h2, 3'h3};
  logic ex [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  dsos_top dsos_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .run_cmd_i(src[0]), .out_voltage_i(src[1]), .steady_i(src[2]),
    .inv_line_i(src[3]), .comm_line_i(src[4]), .speed_search_i(src[5]), .ready_i(src[6]),
    .timer_out_i(src[7]), .onoff_ctrl_i(src[8]), .brake_release_i(src[9]),
    .energy_buffering_i(src[10]), .trip_low_voltage_i(trip[0]), .trip_other_i(trip[1]),
    .restart_fail_i(trip[2]), .open_collector_output_o(oc), .relay_output_o(relay));
  dsos_field_model dsos_field_model_i (.clk_i(clk_i), .open_collector_output_i(oc),
    .relay_output_i(relay), .terminal_level_o(lvl), .relay_contact_o(contact));

  ////////////////////////////////////////////////////////////////////////
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n == 50) miscompares++;
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task report_and_stop;
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #1000000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    wdat = 32'h0; src = 11'h000; trip = 3'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, ofs[i], 32'h0, 4'hF);
      check(rd, 32'(rv[i]));
    end
    wb(1'b1, 8'h40, 32'hFF, 4'hF);
    wb(1'b0, 8'h40, 32'h0, 4'hF);
    check(rd, 32'h0);
    wb(1'b1, dsos_pkg::OFS_TERM_SEL, 32'(dsos_pkg::FN_STOP), 4'h0);
    repeat (4) @(posedge clk_i);
    check(32'(oc), 32'h0);
    wb(1'b1, dsos_pkg::OFS_TERM_SEL, 32'(dsos_pkg::FN_STOP), 4'hF);
    repeat (4) @(posedge clk_i);
    check(32'(oc), 32'h1);
    check(32'(lvl), 32'h0);
    for (int i = 0; i < 2; i++) begin
      src <= 11'(i + 1);
      repeat (4) @(posedge clk_i);
      check(32'(oc), 32'h0);
    end
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, dsos_pkg::OFS_TERM_SEL, 32'(codes[i]), 4'hF);
      src <= 11'h003 | (11'h004 << i);
      repeat (4) @(posedge clk_i);
      check(32'(oc), 32'h1);
      src <= 11'h003;
      repeat (4) @(posedge clk_i);
      check(32'(oc), 32'h0);
    end
    wb(1'b1, dsos_pkg::OFS_RELAY_SEL, 32'(dsos_pkg::FN_TRIP), 4'hF);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, dsos_pkg::OFS_MASK, 32'(mk[i]), 4'hF);
      trip <= tc[i];
      repeat (4) @(posedge clk_i);
      check(32'(relay), 32'(ex[i]));
      trip <= 3'h0;
      repeat (4) @(posedge clk_i);
      check(32'(relay), 32'h0);
    end
    wb(1'b1, dsos_pkg::OFS_ON_DLY, 32'hFFFF, 4'hF);
    wb(1'b0, dsos_pkg::OFS_ON_DLY, 32'h0, 4'hF);
    check(rd, 32'(dsos_pkg::DLY_MAX));
    wb(1'b1, dsos_pkg::OFS_ON_DLY, 32'h1, 4'hF);
    trip <= 3'h2;
    repeat (50000) @(posedge clk_i);
    check(32'(relay), 32'h0);
    trip <= 3'h0;
    wb(1'b1, dsos_pkg::OFS_ON_DLY, 32'h0, 4'hF);
    wb(1'b1, dsos_pkg::OFS_OFF_DLY, 32'h1, 4'hF);
    trip <= 3'h2;
    repeat (4) @(posedge clk_i);
    check(32'(relay), 32'h1);
    trip <= 3'h0;
    repeat (20000) @(posedge clk_i);
    check(32'(relay), 32'h1);
    check(32'(contact), 32'h1);
    wb(1'b1, dsos_pkg::OFS_TERM_SEL, 32'(dsos_pkg::FN_TRIP), 4'hF);
    repeat (4) @(posedge clk_i);
    check(32'(oc), 32'h1);
    wb(1'b0, dsos_pkg::OFS_STATUS, 32'h0, 4'hF);
    check(rd, 32'h0000_0007);
    report_and_stop();
  end
endmodule : dsos_top_test
`default_nettype wire
